// *** hw/aoss_pkg.sv ***
package aoss_pkg;
    // Configuration register layout
    localparam int AOSS_CFG_W = 8;
    localparam int AOSS_SEL_W = 6;
    localparam int AOSS_SEL_LSB = 0;
    localparam int AOSS_INV_BIT = 6;
    localparam logic [7:0] AOSS_PIN_A_CFG_RESET = 8'h3f;
    localparam logic [7:0] AOSS_PIN_B_CFG_RESET = 8'h2e;
    localparam logic [7:0] AOSS_TEMP_SENSOR_CFG = 8'h80;

    // Select codes
    localparam logic [5:0] AOSS_SEL_TX_THRESH = 6'h02;
    localparam logic [5:0] AOSS_SEL_TX_FULL = 6'h03;
    localparam logic [5:0] AOSS_SEL_UNDERFLOW = 6'h05;
    localparam logic [5:0] AOSS_SEL_PKT_SYNC = 6'h06;
    localparam logic [5:0] AOSS_SEL_PLL_LOCK = 6'h0a;
    localparam logic [5:0] AOSS_SEL_SERIAL_CLK = 6'h0b;
    localparam logic [5:0] AOSS_SEL_TEST_LAST = 6'h28;
    localparam logic [5:0] AOSS_SEL_CHIP_RDY = 6'h29;
    localparam logic [5:0] AOSS_SEL_CRYSTAL_STABLE = 6'h2b;
    localparam logic [5:0] AOSS_SEL_DRIVE_EN_N = 6'h2d;
    localparam logic [5:0] AOSS_SEL_HIGH_Z = 6'h2e;
    localparam logic [5:0] AOSS_SEL_CONST_LOW = 6'h2f;
    localparam logic [5:0] AOSS_SEL_DIV_192 = 6'h3f;

    // Crystal clock divided by 192: toggle every half period
    localparam int AOSS_CLK_DIV = 192;
    localparam int AOSS_HALF_DIV = AOSS_CLK_DIV / 2;

    // Controller register offsets
    localparam int AOSS_ADDR_W = 4;
    localparam logic [3:0] AOSS_REG_CFG_A = 4'h0;
    localparam logic [3:0] AOSS_REG_CFG_B = 4'h1;
    localparam logic [3:0] AOSS_REG_CTRL = 4'h2;
    localparam logic [3:0] AOSS_REG_PINS = 4'h3;
    localparam logic [3:0] AOSS_REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] AOSS_REG_IRQ_EN = 4'h5;
    localparam logic [3:0] AOSS_REG_IRQ_CLR = 4'h6;
    localparam logic AOSS_CS_N_RESET = 1'b1;

    // Interrupt status bits
    localparam int AOSS_IRQ_W = 3;
    localparam int AOSS_IRQ_A_RISE = 0;
    localparam int AOSS_IRQ_B_RISE = 1;
    localparam int AOSS_IRQ_REFUSED = 2;

    // Select codes without a defined function
    function automatic logic aoss_sel_reserved(input logic [5:0] sel);
        aoss_sel_reserved = (sel <= 6'h01) || (sel == 6'h04) || (sel >= 6'h07 && sel <= 6'h09)
            || (sel >= 6'h0c && sel <= AOSS_SEL_TEST_LAST) || (sel == 6'h2a) || (sel == 6'h2c);
    endfunction
endpackage

// *** hw/aoss_link_if.sv ***
`timescale 1ns/100ps
interface aoss_link_if;
    logic cfg_wr;
    logic cfg_sel_b;
    logic [7:0] cfg_data;
    logic chip_select_n;
    logic aux_out_a_o;
    logic aux_out_a_oe;
    logic aux_out_b_o;
    logic aux_out_b_oe;
    logic aux_out_a;
    logic aux_out_b;

    // Undriven pins rest high through a pull-up
    assign aux_out_a = aux_out_a_oe ? aux_out_a_o : 1'b1;
    assign aux_out_b = aux_out_b_oe ? aux_out_b_o : 1'b1;

    modport dev (
        input cfg_wr,
        input cfg_sel_b,
        input cfg_data,
        input chip_select_n,
        output aux_out_a_o,
        output aux_out_a_oe,
        output aux_out_b_o,
        output aux_out_b_oe
    );

    modport host (
        output cfg_wr,
        output cfg_sel_b,
        output cfg_data,
        output chip_select_n,
        input aux_out_a,
        input aux_out_b
    );
endinterface

// *** hw/aoss_tick_div.sv ***
`timescale 1ns/100ps
module aoss_tick_div #(
    parameter int N = 2
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    output logic tick // One-cycle pulse every N cycles
);
    localparam int W = (N > 1) ? $clog2(N) : 1;
    localparam logic [W-1:0] LAST = W'(N - 1);

    logic [W-1:0] count;

    // Free-running count, pulse on wrap
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (count == LAST);
            count <= (count == LAST) ? '0 : count + W'(1);
        end
    end
endmodule

// *** hw/aoss_device.sv ***
`timescale 1ns/100ps
// What this block does
// - Two pins, each chosen by 6-bit select
// - Pin B valid only while chip select high
// - Pin B defaults to high impedance
// - Pin A defaults to crystal clock /192
// - Host may rewrite pin A select anytime
// - Value 128 routes temperature sensor to A
// - Sleep: B forced high, A high impedance
// - Code 2: fill at or above threshold
// - Code 3: full until below threshold
// - Code 5: underflow until flush
// - Code 6: sync sent until end/underflow
// - Code 10: PLL lock detector, host interrupt
// - Code 11: serial clock, rising edge sampling
// - Code 45: active-low pin A tri-state enable (low while pin A is serial data input)
// - Host never programs reserved select codes
// - Code 47: constant 0, inverted gives 1
module aoss_device
    import aoss_pkg::*;
(
    input wire logic SYS_CLK, // 20 MHz crystal clock
    input wire logic RSTN, // Synchronous reset, active low
    aoss_link_if.dev LINK, // Pins and config toward host
    input wire logic FIFO_AT_THRESH, // Fill level at or above threshold
    input wire logic FIFO_FULL, // Transmit buffer full
    input wire logic FIFO_UNDERFLOW, // Underflow event pulse
    input wire logic FIFO_FLUSH, // Flush event pulse
    input wire logic SYNC_SENT, // Sync word sent pulse
    input wire logic PACKET_END, // Packet end pulse
    input wire logic PLL_LOCK, // Lock detector level
    input wire logic SERIAL_CLK, // Serial bit clock level
    input wire logic PIN_A_TX_INPUT, // Pin A used as serial data input
    input wire logic CHIP_READY, // Chip ready level
    input wire logic CRYSTAL_STABLE, // Crystal oscillator stable
    input wire logic SLEEP, // Low-power sleep state
    input wire logic SPI_DATA_OUT, // Serial data out while selected
    output logic TEMP_SENSE_EN // Temperature sensor routed to pin A
);
    typedef struct packed {
        logic [7:0] pin_a_config;
        logic [7:0] pin_b_config;
        logic full_flag;
        logic underflow_flag;
        logic packet_flag;
        logic div_clk;
        logic temp_en;
        logic aux_out_a_o;
        logic aux_out_a_oe;
        logic aux_out_b_o;
        logic aux_out_b_oe;
    } aoss_dev_s;

    aoss_dev_s st;
    aoss_dev_s next_st;
    logic half_tick;
    logic [5:0] pin_a_select;
    logic [5:0] pin_b_select;
    logic pin_a_invert;
    logic pin_b_invert;
    logic pin_a_drive_enable_n;

    // Half-period pulse for the divided clock
    aoss_tick_div #(
        .N(AOSS_HALF_DIV)
    ) u_div (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .tick(half_tick)
    );

    // Config fields
    assign pin_a_select = st.pin_a_config[AOSS_SEL_LSB +: AOSS_SEL_W];
    assign pin_b_select = st.pin_b_config[AOSS_SEL_LSB +: AOSS_SEL_W];
    assign pin_a_invert = st.pin_a_config[AOSS_INV_BIT];
    assign pin_b_invert = st.pin_b_config[AOSS_INV_BIT];
    assign pin_a_drive_enable_n = ~PIN_A_TX_INPUT;

    // Digital signal for a select code
    function automatic logic pick(input logic [5:0] sel, input aoss_dev_s s);
        logic v;
        v = 1'b0;
        unique case (sel)
            AOSS_SEL_TX_THRESH: v = FIFO_AT_THRESH;
            AOSS_SEL_TX_FULL: v = s.full_flag;
            AOSS_SEL_UNDERFLOW: v = s.underflow_flag;
            AOSS_SEL_PKT_SYNC: v = s.packet_flag;
            AOSS_SEL_PLL_LOCK: v = PLL_LOCK;
            AOSS_SEL_SERIAL_CLK: v = SERIAL_CLK;
            AOSS_SEL_CHIP_RDY: v = CHIP_READY;
            AOSS_SEL_CRYSTAL_STABLE: v = CRYSTAL_STABLE;
            AOSS_SEL_DRIVE_EN_N: v = pin_a_drive_enable_n;
            AOSS_SEL_CONST_LOW: v = 1'b0;
            AOSS_SEL_DIV_192: v = s.div_clk;
            default: v = 1'b0;
        endcase
        pick = v;
    endfunction

    // Next state
    always_comb begin
        next_st = st;

        // Configuration writes from the host
        if (LINK.cfg_wr) begin
            if (LINK.cfg_sel_b) begin
                next_st.pin_b_config = LINK.cfg_data;
            end else begin
                // Any write other than the sensor value turns the sensor off
                next_st.pin_a_config = LINK.cfg_data;
                next_st.temp_en = (LINK.cfg_data == AOSS_TEMP_SENSOR_CFG);
            end
        end

        // Full flag: set by full, cleared below threshold; set wins
        if (FIFO_FULL) begin
            next_st.full_flag = 1'b1;
        end else if (!FIFO_AT_THRESH) begin
            next_st.full_flag = 1'b0;
        end

        // Underflow flag: held until flush; set wins
        if (FIFO_UNDERFLOW) begin
            next_st.underflow_flag = 1'b1;
        end else if (FIFO_FLUSH) begin
            next_st.underflow_flag = 1'b0;
        end

        // Packet flag: sync sent until packet end or underflow
        if (SYNC_SENT) begin
            next_st.packet_flag = 1'b1;
        end else if (PACKET_END || FIFO_UNDERFLOW) begin
            next_st.packet_flag = 1'b0;
        end

        // Divided crystal clock, running from reset
        if (half_tick) begin
            // Free-running so the host can use it before any write
            next_st.div_clk = ~st.div_clk;
        end

        // Pin A drive
        if (SLEEP) begin
            // Released in sleep whatever the select
            next_st.aux_out_a_o = 1'b0;
            next_st.aux_out_a_oe = 1'b0;
        end else if (st.temp_en) begin
            // Analog voltage owns the pin, no digital drive
            next_st.aux_out_a_o = 1'b0;
            next_st.aux_out_a_oe = 1'b0;
        end else if (PIN_A_TX_INPUT || pin_a_select == AOSS_SEL_HIGH_Z) begin
            // Pin taken as serial data input, or tri-stated
            next_st.aux_out_a_o = 1'b0;
            next_st.aux_out_a_oe = 1'b0;
        end else begin
            // Selected signal, polarity set by the invert bit
            next_st.aux_out_a_o = pick(pin_a_select, st) ^ pin_a_invert;
            next_st.aux_out_a_oe = 1'b1;
        end

        // Pin B drive, shared with serial data out
        if (SLEEP) begin
            // Held high in sleep whatever the select
            next_st.aux_out_b_o = 1'b1;
            next_st.aux_out_b_oe = 1'b1;
        end else if (!LINK.chip_select_n) begin
            // Serial data out owns the line while selected
            next_st.aux_out_b_o = SPI_DATA_OUT;
            next_st.aux_out_b_oe = 1'b1;
        end else if (pin_b_select == AOSS_SEL_HIGH_Z) begin
            // Released so a shared bus is left alone
            next_st.aux_out_b_o = 1'b0;
            next_st.aux_out_b_oe = 1'b0;
        end else begin
            // Selected signal, meaningful only while deselected
            next_st.aux_out_b_o = pick(pin_b_select, st) ^ pin_b_invert;
            next_st.aux_out_b_oe = 1'b1;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            // Config defaults: A shows the divided clock, B released
            st.pin_a_config <= AOSS_PIN_A_CFG_RESET;
            st.pin_b_config <= AOSS_PIN_B_CFG_RESET;

            // Event flags and sensor start clear
            st.full_flag <= 1'b0;
            st.underflow_flag <= 1'b0;
            st.packet_flag <= 1'b0;
            st.div_clk <= 1'b0;
            st.temp_en <= 1'b0;

            // Pin A driven from the first cycle, pin B left to the bus
            st.aux_out_a_o <= 1'b0;
            st.aux_out_a_oe <= 1'b1;
            st.aux_out_b_o <= 1'b0;
            st.aux_out_b_oe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign LINK.aux_out_a_o = st.aux_out_a_o;
    assign LINK.aux_out_a_oe = st.aux_out_a_oe;
    assign LINK.aux_out_b_o = st.aux_out_b_o;
    assign LINK.aux_out_b_oe = st.aux_out_b_oe;
    assign TEMP_SENSE_EN = st.temp_en;
endmodule

// *** hw/aoss_host.sv ***
`timescale 1ns/100ps
module aoss_host
    import aoss_pkg::*;
(
    input wire logic SYS_CLK, // 20 MHz clock
    input wire logic RSTN, // Synchronous reset, active low
    aoss_link_if.host LINK, // Pins and config toward device
    input wire logic [3:0] REG_ADDR, // Register address
    input wire logic [7:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [7:0] REG_RDATA, // Read data, cycle after strobe
    output logic IRQ // Level interrupt
);
    typedef struct packed {
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic cs_n;
        logic cs_prev;
        logic cfg_wr;
        logic cfg_sel_b;
        logic [7:0] cfg_data;
        logic a_last;
        logic b_last;
        logic b_valid;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic [7:0] rdata;
        logic irq;
    } aoss_host_s;

    aoss_host_s st;
    aoss_host_s next_st;
    logic [2:0] events;
    logic [2:0] clear;
    logic refused;
    logic b_ok;

    always_comb begin
        next_st = st;
        events = '0;
        clear = '0;
        refused = 1'b0;
        // Pin B carries its selection only after chip select stays high
        b_ok = st.cs_n && st.cs_prev;
        next_st.cfg_wr = 1'b0;
        next_st.rdata = '0;
        next_st.cs_prev = st.cs_n;

        // Register writes; reserved codes are refused
        if (REG_WR) begin
            unique case (REG_ADDR)
                AOSS_REG_CFG_A, AOSS_REG_CFG_B: begin
                    refused = aoss_sel_reserved(REG_WDATA[AOSS_SEL_LSB +: AOSS_SEL_W])
                        && !(REG_ADDR == AOSS_REG_CFG_A && REG_WDATA == AOSS_TEMP_SENSOR_CFG);
                    if (!refused) begin
                        next_st.cfg_wr = 1'b1;
                        next_st.cfg_sel_b = (REG_ADDR == AOSS_REG_CFG_B);
                        next_st.cfg_data = REG_WDATA;
                        if (REG_ADDR == AOSS_REG_CFG_B) begin
                            next_st.cfg_b = REG_WDATA;
                        end else begin
                            next_st.cfg_a = REG_WDATA;
                        end
                    end
                end
                AOSS_REG_CTRL: next_st.cs_n = REG_WDATA[0];
                AOSS_REG_IRQ_EN: next_st.irq_en = REG_WDATA[AOSS_IRQ_W-1:0];
                AOSS_REG_IRQ_CLR: clear = REG_WDATA[AOSS_IRQ_W-1:0];
                default: ;
            endcase
        end

        // Rising edges; a lock shows as a rise on the watched pin
        next_st.a_last = LINK.aux_out_a;
        next_st.b_last = LINK.aux_out_b;
        next_st.b_valid = b_ok;
        events[AOSS_IRQ_A_RISE] = LINK.aux_out_a && !st.a_last;
        events[AOSS_IRQ_B_RISE] = b_ok && st.b_valid && LINK.aux_out_b && !st.b_last;
        events[AOSS_IRQ_REFUSED] = refused;

        // Sticky status, set wins over clear
        next_st.irq_stat = (st.irq_stat & ~clear) | events;
        next_st.irq = |(next_st.irq_stat & next_st.irq_en);

        // Read data for the cycle after the strobe
        if (REG_RD) begin
            unique case (REG_ADDR)
                AOSS_REG_CFG_A: next_st.rdata = st.cfg_a;
                AOSS_REG_CFG_B: next_st.rdata = st.cfg_b;
                AOSS_REG_CTRL: next_st.rdata = {7'h00, st.cs_n};
                AOSS_REG_PINS: next_st.rdata = {5'h00, b_ok, LINK.aux_out_b & b_ok, LINK.aux_out_a};
                AOSS_REG_IRQ_STAT: next_st.rdata = {5'h00, st.irq_stat};
                AOSS_REG_IRQ_EN: next_st.rdata = {5'h00, st.irq_en};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            st.cfg_a <= AOSS_PIN_A_CFG_RESET;
            st.cfg_b <= AOSS_PIN_B_CFG_RESET;
            st.cs_n <= AOSS_CS_N_RESET;
            st.cs_prev <= AOSS_CS_N_RESET;
            st.cfg_wr <= 1'b0;
            st.cfg_sel_b <= 1'b0;
            st.cfg_data <= 8'h00;
            st.a_last <= 1'b1;
            st.b_last <= 1'b1;
            st.b_valid <= 1'b0;
            st.irq_stat <= 3'h0;
            st.irq_en <= 3'h0;
            st.rdata <= 8'h00;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign LINK.cfg_wr = st.cfg_wr;
    assign LINK.cfg_sel_b = st.cfg_sel_b;
    assign LINK.cfg_data = st.cfg_data;
    assign LINK.chip_select_n = st.cs_n;
    assign REG_RDATA = st.rdata;
    assign IRQ = st.irq;
endmodule

// *** test/aoss_link_chk.sv ***
`timescale 1ns/100ps
module aoss_link_chk
    import aoss_pkg::*;
(
    input wire logic SYS_CLK, // Clock
    input wire logic RSTN, // Reset, active low
    input wire logic cfg_wr, // Config write
    input wire logic cfg_sel_b, // Config target
    input wire logic [7:0] cfg_data, // Config value
    input wire logic chip_select_n, // Chip select
    input wire logic aux_out_a_o, // Pin A drive
    input wire logic aux_out_a_oe, // Pin A enable
    input wire logic aux_out_b_o, // Pin B drive
    input wire logic aux_out_b_oe, // Pin B enable
    input wire logic SLEEP, // Sleep state
    input wire logic SPI_DATA_OUT, // Serial data out
    input wire logic PIN_A_TX_INPUT // Pin A as input
);
    logic [7:0] a_cfg;
    logic [7:0] b_cfg;
    logic [7:0] cnt;
    logic [1:0] stage;
    logic prev_a;
    logic chg;
    logic rsv;
    logic [5:0] ws;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    // Mirror of accepted configs
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            a_cfg <= AOSS_PIN_A_CFG_RESET;
            b_cfg <= AOSS_PIN_B_CFG_RESET;
        end else if (cfg_wr && cfg_sel_b) begin
            b_cfg <= cfg_data;
        end else if (cfg_wr) begin
            a_cfg <= cfg_data;
        end
    end

    // Interval between pin A edges, trusted after two clean edges
    assign chg = aux_out_a_o != prev_a;
    always_ff @(posedge SYS_CLK) begin
        prev_a <= aux_out_a_o;
        cnt <= chg ? 8'h01 : cnt + 8'h01;
        if (!RSTN || cfg_wr || SLEEP || PIN_A_TX_INPUT || !aux_out_a_oe || a_cfg != AOSS_PIN_A_CFG_RESET) begin
            stage <= 2'h0;
        end else if (chg && !stage[1]) begin
            stage <= stage + 2'h1;
        end
    end

    // Codes without a function
    assign ws = cfg_data[5:0];
    assign rsv = ws <= 6'h01 || ws == 6'h04 || (ws >= 6'h07 && ws <= 6'h09) || (ws >= 6'h0c && ws <= 6'h28)
        || ws == 6'h2a || ws == 6'h2c;

    property p_b_reset;
        $rose(RSTN) |-> !aux_out_b_oe;
    endproperty
    a_b_reset: assert property (p_b_reset) else $error("pin B driven after reset");
    property p_a_reset;
        $rose(RSTN) |-> aux_out_a_oe && !aux_out_a_o;
    endproperty
    a_a_reset: assert property (p_a_reset) else $error("pin A not clock after reset");
    property p_a_div;
        chg && stage[1] |-> cnt == 8'h60;
    endproperty
    a_a_div: assert property (p_a_div) else $error("pin A half period wrong");
    property p_const;
        !a_cfg[7] && a_cfg[5:0] == AOSS_SEL_CONST_LOW && !SLEEP && !PIN_A_TX_INPUT
            |=> aux_out_a_oe && aux_out_a_o == $past(a_cfg[6]);
    endproperty
    a_const: assert property (p_const) else $error("pin A constant wrong");
    property p_b_spi;
        !chip_select_n && !SLEEP |=> aux_out_b_oe && aux_out_b_o == $past(SPI_DATA_OUT);
    endproperty
    a_b_spi: assert property (p_b_spi) else $error("pin B not data out");
    property p_sleep;
        SLEEP |=> aux_out_b_oe && aux_out_b_o && !aux_out_a_oe;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep pin levels wrong");
    property p_temp;
        a_cfg == AOSS_TEMP_SENSOR_CFG |=> !aux_out_a_oe;
    endproperty
    a_temp: assert property (p_temp) else $error("pin A driven in sensor mode");
    property p_b_hiz;
        chip_select_n && !SLEEP && b_cfg[5:0] == AOSS_SEL_HIGH_Z |=> !aux_out_b_oe;
    endproperty
    a_b_hiz: assert property (p_b_hiz) else $error("pin B driven in high impedance");
    property p_no_rsv;
        cfg_wr |-> !rsv || (!cfg_sel_b && cfg_data == AOSS_TEMP_SENSOR_CFG);
    endproperty
    a_no_rsv: assert property (p_no_rsv) else $error("reserved code sent");
endmodule

// *** test/tb.sv ***
`timescale 1ns/100ps
module tb
    import aoss_pkg::*;
;
    typedef struct {
        logic [7:0] e;
        logic [7:0] m;
        logic [3:0] a;
    } aoss_note_s;
    localparam logic [5:0] LVL [7] = '{6'h02, 6'h0a, 6'h0b, 6'h29, 6'h2b, 6'h2d, 6'h2f};
    localparam logic [5:0] RSV [9] = '{6'h00, 6'h01, 6'h04, 6'h07, 6'h09, 6'h0c, 6'h28, 6'h2a, 6'h2c};
    // Code, expected, full, threshold, underflow, flush, sync, packet end
    localparam logic [12:0] STEPS [15] = '{{6'h03, 7'b1110000}, {6'h03, 7'b1010000}, {6'h03, 7'b0000000},
        {6'h03, 7'b0010000}, {6'h05, 7'b1001000}, {6'h05, 7'b1000000}, {6'h05, 7'b0000100},
        {6'h05, 7'b1001100}, {6'h05, 7'b0000100}, {6'h06, 7'b1000010}, {6'h06, 7'b0000001},
        {6'h06, 7'b1000010}, {6'h06, 7'b0001000}, {6'h06, 7'b1000011}, {6'h06, 7'b0000001}};
    logic clk, rstn, wr_s, rd_s, irq, temp_en, inv;
    logic thr, full, ufl, flush, sync, pend, lock, sclk, atx, crdy, xstb, slp, sdo;
    logic rd_d = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, lv;
    logic [31:0] v;
    logic [12:0] s;
    logic [5:0] pc;
    int fails = 0;
    int check_count = 0;
    int seed = 32'hb7c1d384;
    aoss_note_s notes[$];
    aoss_note_s cur;

    aoss_link_if link();
    aoss_device aoss_device_inst (.SYS_CLK(clk), .RSTN(rstn), .LINK(link.dev), .FIFO_AT_THRESH(thr),
        .FIFO_FULL(full), .FIFO_UNDERFLOW(ufl), .FIFO_FLUSH(flush), .SYNC_SENT(sync), .PACKET_END(pend),
        .PLL_LOCK(lock), .SERIAL_CLK(sclk), .PIN_A_TX_INPUT(atx), .CHIP_READY(crdy), .CRYSTAL_STABLE(xstb),
        .SLEEP(slp), .SPI_DATA_OUT(sdo), .TEMP_SENSE_EN(temp_en));
    aoss_host aoss_host_inst (.SYS_CLK(clk), .RSTN(rstn), .LINK(link.host), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .IRQ(irq));
    aoss_link_chk aoss_link_chk_inst (.SYS_CLK(clk), .RSTN(rstn), .cfg_wr(link.cfg_wr), .cfg_sel_b(link.cfg_sel_b),
        .cfg_data(link.cfg_data), .chip_select_n(link.chip_select_n), .aux_out_a_o(link.aux_out_a_o),
        .aux_out_a_oe(link.aux_out_a_oe), .aux_out_b_o(link.aux_out_b_o), .aux_out_b_oe(link.aux_out_b_oe),
        .SLEEP(slp), .SPI_DATA_OUT(sdo), .PIN_A_TX_INPUT(atx));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
        check_count++;
        if ((g & m) !== (e & m)) begin
            $display("mismatch %s expected %h seen %h", n, e & m, g & m);
            fails++;
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        aoss_note_s n;
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        n.e = e;
        n.m = m;
        n.a = a;
        notes.push_back(n);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    task automatic irq_is(input logic e);
        idle(2);
        cmp("irq", {7'h00, e}, {7'h00, irq}, 8'h01);
    endtask

    task automatic end_sim();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data checked against the oldest note
    always @(posedge clk) begin
        rd_d <= rd_s;
        if (rd_d === 1'b1 && notes.size() == 0) begin
            fails++;
            $display("mismatch read note expected one seen none");
        end else if (rd_d === 1'b1) begin
            cur = notes.pop_front();
            cmp($sformatf("reg %h", cur.a), cur.e, rdata, cur.m);
        end
    end

    // Main sequence
    initial begin
        {rstn, wr_s, rd_s, thr, full, ufl, flush, sync, pend, lock, sclk, atx, crdy, xstb, slp, sdo} = 16'h0000;
        addr = 4'h0;
        wdata = 8'h00;
        pc = 6'h00;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(AOSS_REG_CFG_A, AOSS_PIN_A_CFG_RESET, 8'hff);
        rd(AOSS_REG_CFG_B, AOSS_PIN_B_CFG_RESET, 8'hff);
        rd(AOSS_REG_CTRL, 8'h01, 8'hff);
        rd(AOSS_REG_PINS, 8'h06, 8'h06);
        rd(4'hf, 8'h00, 8'hff);
        idle(400);
        // Level codes on pin B with random inputs, both polarities
        for (int i = 0; i < 28; i++) begin
            v = $random(seed);
            inv = i[0];
            {atx, xstb, crdy, sclk, lock, thr} <= v[5:0];
            lv = {2'b00, ~v[5], v[4:0]};
            wr(AOSS_REG_CFG_B, {1'b0, inv, LVL[i / 4]});
            idle(3);
            rd(AOSS_REG_PINS, {6'h01, lv[i / 4] ^ inv, 1'b0}, 8'h06);
        end
        atx <= 1'b0;
        rd(AOSS_REG_IRQ_STAT, 8'h02, 8'h02);
        // Buffer and packet flags
        for (int i = 0; i < 15; i++) begin
            s = STEPS[i];
            if (s[12:7] != pc) begin
                wr(AOSS_REG_CFG_B, {2'b00, s[12:7]});
                pc = s[12:7];
            end
            @(posedge clk);
            {full, thr, ufl, flush, sync, pend} <= s[5:0];
            @(posedge clk);
            {ufl, flush, sync, pend} <= 4'h0;
            idle(3);
            rd(AOSS_REG_PINS, {6'h01, s[6], 1'b0}, 8'h06);
        end
        {full, thr} <= 2'b00;
        // Shared data-out line
        wr(AOSS_REG_CTRL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            v = $random(seed);
            sdo <= v[0];
        end
        rd(AOSS_REG_PINS, 8'h00, 8'h06);
        wr(AOSS_REG_CTRL, 8'h01);
        idle(3);
        rd(AOSS_REG_PINS, 8'h04, 8'h06);
        // Pin A levels and interrupt
        wr(AOSS_REG_CFG_A, 8'h2f);
        idle(3);
        wr(AOSS_REG_IRQ_CLR, 8'h07);
        wr(AOSS_REG_IRQ_EN, 8'h01);
        irq_is(1'b0);
        rd(AOSS_REG_PINS, 8'h04, 8'h07);
        wr(AOSS_REG_CFG_A, 8'h6f);
        idle(4);
        rd(AOSS_REG_PINS, 8'h05, 8'h07);
        rd(AOSS_REG_IRQ_STAT, 8'h01, 8'h01);
        irq_is(1'b1);
        wr(AOSS_REG_IRQ_EN, 8'h00);
        irq_is(1'b0);
        wr(AOSS_REG_IRQ_EN, 8'h01);
        irq_is(1'b1);
        wr(AOSS_REG_IRQ_CLR, 8'h01);
        irq_is(1'b0);
        // Reserved codes dropped by the host
        wr(AOSS_REG_CFG_A, 8'h2f);
        foreach (RSV[i]) begin
            wr(AOSS_REG_CFG_A, {2'b00, RSV[i]});
            rd(AOSS_REG_CFG_A, 8'h2f, 8'hff);
        end
        rd(AOSS_REG_IRQ_STAT, 8'h04, 8'h04);
        // Temperature sensor routing
        wr(AOSS_REG_CFG_A, AOSS_TEMP_SENSOR_CFG);
        idle(3);
        rd(AOSS_REG_CFG_A, 8'h80, 8'hff);
        rd(AOSS_REG_PINS, 8'h01, 8'h01);
        cmp("temp enable", 8'h01, {7'h00, temp_en}, 8'h01);
        wr(AOSS_REG_CFG_A, 8'h3f);
        idle(3);
        cmp("temp enable", 8'h00, {7'h00, temp_en}, 8'h01);
        // Sleep state
        slp <= 1'b1;
        wr(AOSS_REG_CFG_A, 8'h2f);
        idle(3);
        rd(AOSS_REG_PINS, 8'h07, 8'h07);
        slp <= 1'b0;
        idle(3);
        rd(AOSS_REG_PINS, 8'h04, 8'h07);
        idle(3);
        end_sim();
    end
endmodule
